// [logic/tps_pkg.sv]
// Constants and carrier types shared by the timer and prescaler block
package tps_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] TC_ADDR  = 8'h01;
  localparam logic [7:0] IC_ADDR  = 8'h0b;
  localparam logic [7:0] CFG_ADDR = 8'h81;
  localparam logic [7:0] DIR_ADDR = 8'h85;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] TC_RST   = 8'h00;
  localparam logic [7:0] IC_RST   = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'hff;
  localparam logic [7:0] DIR_RST  = 8'h1f;
  localparam logic [7:0] DIR_MASK = 8'h1f;

  // ---------------------------------------------------------------
  // Field positions in the interrupt control register
  // ---------------------------------------------------------------
  localparam int IC_FLAG_BIT = 2;
  localparam int IC_EN_BIT   = 5;

  // ---------------------------------------------------------------
  // Phases and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] PH_SECOND    = 2'h1;
  localparam logic [1:0] PH_FOURTH    = 2'h3;
  localparam int         PH_PER_CYCLE = 4;
  localparam int         CLK_NS       = 20;
  localparam int         TOSC_NS      = 20;
  localparam int         INH_CYCLES   = 2;
  localparam int         LAT_CYCLES   = 3;
  localparam logic [3:0] INH_CLK      = 4'(INH_CYCLES * PH_PER_CYCLE * TOSC_NS / CLK_NS);
  localparam logic [3:0] LAT_CLK      = 4'(LAT_CYCLES * PH_PER_CYCLE * TOSC_NS / CLK_NS);
  localparam int         PSC_W        = 8;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tps_bus_s;

  typedef struct packed {
    logic [1:0] spare;
    logic       count_source_sel;
    logic       count_edge_sel;
    logic       scaler_assign;
    logic [2:0] ratio_field;
  } tps_cfg_s;

  typedef struct packed {
    logic s2;
    logic s1;
  } tps_sync_s;

endpackage

// [logic/tps_sync.sv]
// Two-stage synchroniser for the external count pin
`timescale 1ns/1ps
module tps_sync
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Level from outside and its synchronised copy
  input  wire logic async_in,
  output logic      sync_out
);

  tps_sync_s st_r;
  tps_sync_s st_nxt;

  // Shift through two stages; only the second is looked at
  always_comb
  begin
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign sync_out = st_r.s2;

endmodule

// [logic/tps_scaler.sv]
// Shared prescaler counter with clear and advance
`timescale 1ns/1ps
module tps_scaler
  import tps_pkg::*;
#(
  parameter int W = PSC_W
)
(
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // Control
  input  wire logic         clr_in,
  input  wire logic         adv_in,
  // Count value, never visible to software
  output logic [W-1:0]      cnt_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tps_psc_s;

  tps_psc_s st_r;
  tps_psc_s st_nxt;

  // Binary count; each bit toggles at half the rate of the one below,
  // so every tap is a symmetric square wave. Clear wins over advance.
  always_comb
  begin
    st_nxt = st_r;
    if (clr_in)
      st_nxt.cnt = '0;
    else if (adv_in)
      st_nxt.cnt = st_r.cnt + W'(1);
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign cnt_out = st_r.cnt;

endmodule

// [logic/tps_top.sv]
// Eight-bit timer/counter with shared prescaler and register port
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

module tps_top
  import tps_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Register port
  input  wire tps_bus_s   bus_in,
  output logic [7:0]      rd_data_out,
  // External count pin
  input  wire logic       ext_count_in,
  // Watchdog side
  input  wire logic       wdt_tick_in,
  input  wire logic       watchdog_clear_instr_in,
  output logic            wdt_timeout_out,
  // Status and configuration out
  output logic            irq_out,
  output logic [7:0]      port_a_dir_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tc;
    logic [7:0] ic;
    tps_cfg_s   cfg;
    logic [7:0] dir;
    logic [1:0] ph;
    logic       src_prev;
    logic       samp;
    logic [3:0] inh;
    logic [3:0] lat;
    logic       irq;
    logic       wdt_to;
    logic [7:0] rd_data;
  } tps_top_s;

  tps_top_s         st_r;
  tps_top_s         st_nxt;
  logic             ext_sync;
  logic             ext_lvl;
  logic             src_lvl;
  logic             src_rise;
  logic             scl_lvl;
  logic             samp_now;
  logic             inc_pulse;
  logic             step;
  logic             ovf;
  logic             tmr_owns;
  logic             psc_adv;
  logic             psc_clr;
  logic [PSC_W-1:0] pcnt;
  logic [PSC_W-1:0] wdt_mask;
  logic             wdt_hit;
  logic             tc_wr;
  logic             ic_wr;
  logic             cfg_wr;
  logic             dir_wr;

  // Address match, used for both reads and writes
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------

  // Pin synchroniser
  tps_sync u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in (ext_count_in),
    .sync_out (ext_sync)
  );

  tps_scaler #(.W(PSC_W)) u_scaler (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .clr_in   (psc_clr),
    .adv_in   (psc_adv),
    .cnt_out  (pcnt)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------

  // Write strobes per register
  assign tc_wr  = bus_in.wr && reg_hit(bus_in.addr, TC_ADDR);
  assign ic_wr  = bus_in.wr && reg_hit(bus_in.addr, IC_ADDR);
  assign cfg_wr = bus_in.wr && reg_hit(bus_in.addr, CFG_ADDR);
  assign dir_wr = bus_in.wr && reg_hit(bus_in.addr, DIR_ADDR);

  // ---------------------------------------------------------------
  // Count path
  // ---------------------------------------------------------------

  // assignment bit clear means the timer owns the prescaler
  assign tmr_owns = !st_r.cfg.scaler_assign;

  // edge polarity folded into the level, then source chosen
  assign ext_lvl  = ext_sync ^ st_r.cfg.count_edge_sel;
  assign src_lvl  = st_r.cfg.count_source_sel ? ext_lvl : st_r.ph[1];
  assign src_rise = src_lvl && !st_r.src_prev;

  // timer tap n rises once every two to n plus one source edges
  assign scl_lvl  = tmr_owns ? pcnt[st_r.cfg.ratio_field] : src_lvl;

  // sampling points on second and fourth phase
  assign samp_now  = (st_r.ph == PH_SECOND) || (st_r.ph == PH_FOURTH);
  assign inc_pulse = samp_now && scl_lvl && !st_r.samp;

  // steps are dropped while the hold-off runs
  assign step = inc_pulse && (st_r.inh == 4'h0) && !tc_wr;
  assign ovf  = step && (st_r.tc == 8'hff);

  // prescaler input depends on its owner
  assign psc_adv = tmr_owns ? src_rise : wdt_tick_in;

  assign psc_clr = (tmr_owns && tc_wr) ||
                   (!tmr_owns && watchdog_clear_instr_in);

  // watchdog divides by two to n; unscaled when the timer owns it
  assign wdt_mask = PSC_W'((PSC_W'(1) << st_r.cfg.ratio_field) - PSC_W'(1));
  assign wdt_hit  = wdt_tick_in &&
                    (tmr_owns || ((pcnt & wdt_mask) == wdt_mask));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Phases, registers, count, flag, latency and read data
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.ph       = st_r.ph + 2'h1;
    st_nxt.src_prev = src_lvl;
    st_nxt.wdt_to   = wdt_hit;
    // sampled level only moves at the sampling phases
    if (samp_now)
      st_nxt.samp = scl_lvl;
    // configuration may change at any time
    if (cfg_wr)
      st_nxt.cfg = tps_cfg_s'(bus_in.wdata);
    if (dir_wr)
      st_nxt.dir = bus_in.wdata & DIR_MASK;
    if (ic_wr)
      st_nxt.ic = bus_in.wdata;
    // write loads the count and starts the hold-off
    if (tc_wr)
    begin
      st_nxt.tc  = bus_in.wdata;
      st_nxt.inh = INH_CLK;
    end
    else if (st_r.inh != 4'h0)
      st_nxt.inh = st_r.inh - 4'h1;
    // increment lands a few clocks after the pin edge
    else if (inc_pulse)
      st_nxt.tc = st_r.tc + 8'h01;
    // rollover sets the flag, winning over a clear
    if (ovf)
      st_nxt.ic[IC_FLAG_BIT] = 1'b1;
    // latency count starts when the flag rises
    if (!st_r.ic[IC_FLAG_BIT] && st_nxt.ic[IC_FLAG_BIT])
      st_nxt.lat = LAT_CLK;
    else if (st_r.lat != 4'h0)
      st_nxt.lat = st_r.lat - 4'h1;
    st_nxt.irq = st_nxt.ic[IC_FLAG_BIT] && st_nxt.ic[IC_EN_BIT] &&
                 (st_nxt.lat == 4'h0);
    // prescaler is not in the read map; unmapped reads give zero
    st_nxt.rd_data = 8'h00;
    if (bus_in.rd)
    begin
      if (reg_hit(bus_in.addr, TC_ADDR))
        st_nxt.rd_data = st_r.tc;
      else if (reg_hit(bus_in.addr, IC_ADDR))
        st_nxt.rd_data = st_r.ic;
      else if (reg_hit(bus_in.addr, CFG_ADDR))
        st_nxt.rd_data = st_r.cfg;
      else if (reg_hit(bus_in.addr, DIR_ADDR))
        st_nxt.rd_data = st_r.dir;
    end
  end

  // State register
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      st_r          <= '0;
      st_r.tc       <= TC_RST;
      st_r.ic       <= IC_RST;
      st_r.cfg      <= tps_cfg_s'(CFG_RST);
      st_r.dir      <= DIR_RST;
      // detectors start at the folded idle level of the reset config
      // (pin low, falling edge), so no false step follows reset
      st_r.samp     <= 1'b1;
      st_r.src_prev <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rd_data_out     = st_r.rd_data;
  assign irq_out         = st_r.irq;
  assign wdt_timeout_out = st_r.wdt_to;
  assign port_a_dir_out  = st_r.dir;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  // sampled level changes only after a sampling phase
  samp_phase_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $changed(st_r.samp) |->
        ($past(st_r.ph) == PH_SECOND || $past(st_r.ph) == PH_FOURTH))
    else $error("sampled level moved outside sampling phase");

  // no step for eight clocks after a count write
  inc_inhibit_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      tc_wr |=> (!step)[*8])
    else $error("count stepped during write hold-off");

  // written value is what the register holds next
  tc_load_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      tc_wr |=> (st_r.tc == $past(bus_in.wdata)))
    else $error("count write not loaded");

  ovf_flag_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      ovf |=> st_r.ic[IC_FLAG_BIT] && (st_r.tc == 8'h00))
    else $error("rollover did not set flag");

  // flag stays until software clears it
  flag_hold_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      st_r.ic[IC_FLAG_BIT] && !(ic_wr && !bus_in.wdata[IC_FLAG_BIT])
        |=> st_r.ic[IC_FLAG_BIT])
    else $error("overflow flag dropped without clear");

  // count write clears the prescaler while the timer owns it
  tmr_clear_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      tc_wr && tmr_owns |=> (pcnt == '0))
    else $error("prescaler not cleared by count write");

  // watchdog clear clears the prescaler while the watchdog owns it
  wdt_clear_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      watchdog_clear_instr_in && !tmr_owns |=> (pcnt == '0))
    else $error("prescaler not cleared by watchdog clear");

  // request stays low right after the flag rises
  irq_quiet_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $rose(st_r.ic[IC_FLAG_BIT]) |-> (!st_r.irq)[*8])
    else $error("interrupt request came too early");

  // request appears twelve clocks after the flag rises
  irq_delay_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      $rose(st_r.ic[IC_FLAG_BIT]) |-> ##12
        (st_r.irq || ($past(st_r.lat) != 4'h0) ||
         !$past(st_r.ic[IC_FLAG_BIT]) || !$past(st_r.ic[IC_EN_BIT])))
    else $error("interrupt request latency wrong");

  // watchdog runs unscaled while the timer owns the prescaler
  wdt_unscaled_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      wdt_tick_in && tmr_owns |=> st_r.wdt_to)
    else $error("watchdog tick lost while unscaled");

  // ratio zero passes every watchdog tick
  wdt_ratio_a:
    assert property (@(posedge clk_in) disable iff (!rst_b_in)
      wdt_tick_in && !tmr_owns && (st_r.cfg.ratio_field == 3'h0)
        |=> st_r.wdt_to)
    else $error("watchdog ratio zero not passing ticks");

endmodule

// [testbench/tps_src.sv]
// External pulse source standing on the count pin
`timescale 1ns/1ps
module tps_src
(
  // Clock used only to pace the pulses
  input  wire logic clk_in,
  // Count pin level
  output logic      pin_out
);
  // Pin rests low between bursts
  initial pin_out = 1'b0;

  // Moves the pin right after an edge; the block sees it through two flops
  task automatic hold_level(input logic lv);
    @(posedge clk_in);
    pin_out <= lv;
  endtask

  task automatic burst(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++)
    begin
      hold_level(1'b1);
      repeat (hi - 1) @(posedge clk_in);
      hold_level(1'b0);
      repeat (lo - 1) @(posedge clk_in);
    end
  endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the timer and prescaler block
`timescale 1ns/1ps
module tb
  import tps_pkg::*;
;
  // Stimulus and observation
  logic       clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  tps_bus_s   bus_r = '0;
  logic       tick_r = 1'b0;
  logic       wclr_r = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] dir;
  logic [7:0] v;
  logic       pin;
  logic       wto;
  logic       irq;
  int         bad_count = 0;
  int         tests_run = 0;
  int         seed = 46809;
  int         to_cnt = 0;
  int         n;
  int         k;

  // Clock at 50 MHz
  always #10 clk_in = ~clk_in;

  // Counts postscaled watchdog pulses
  always @(posedge clk_in)
    if (wto === 1'b1)
      to_cnt <= to_cnt + 1;

  tps_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_r), .rd_data_out(rd_data),
    .ext_count_in(pin), .wdt_tick_in(tick_r), .watchdog_clear_instr_in(wclr_r),
    .wdt_timeout_out(wto), .irq_out(irq), .port_a_dir_out(dir));
  tps_src src (.clk_in(clk_in), .pin_out(pin));

  // Clocks per count step for a timer ratio
  function automatic int tmr_div(input int r);
    return 4 << (r + 1);
  endfunction

  // Step bounds over a wait of six periods less the hold-off
  function automatic int steps_lo(input int p);
    return (6 * p - 6) / p - ((p > 4) ? 1 : 0);
  endfunction
  function automatic int steps_hi(input int p);
    return (7 * p - 7) / p;
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] g);
    logic ok;
    ok = (g >= lo && g <= hi);
    tests_run++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // Register port cycles
  task automatic bwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_r <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_r.wr <= 1'b0;
  endtask

  task automatic brd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_r <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_r.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    brd(a, d);
    chk8(nm, e, d);
  endtask

  // Watchdog clear instruction and base ticks
  task automatic pulse_clr();
    @(posedge clk_in);
    wclr_r <= 1'b1;
    @(posedge clk_in);
    wclr_r <= 1'b0;
  endtask

  task automatic ticks(input int c, output int got);
    int s;
    s = to_cnt;
    repeat (c)
    begin
      @(posedge clk_in);
      tick_r <= 1'b1;
      @(posedge clk_in);
      tick_r <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
    got = to_cnt - s;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rchk("config", CFG_ADDR, CFG_RST);
    rchk("count", TC_ADDR, TC_RST);
    rchk("irq_ctrl", IC_ADDR, IC_RST);
    rchk("dir", DIR_ADDR, DIR_RST);
    chk8("dir_pin", DIR_RST, dir);
    for (int i = 0; i < 6; i++)
    begin
      v = 8'($random(seed));
      bwr(TC_ADDR, v);
      bwr({v[7:2], 2'b10}, ~v);
      rchk("count_rw", TC_ADDR, v);
      rchk("unmapped", {v[7:2], 2'b10}, 8'h00);
      bwr(DIR_ADDR, v);
      rchk("dir_rw", DIR_ADDR, v & DIR_MASK);
    end
    // Unscaled pin counting, both edges
    for (int e = 0; e < 2; e++)
    begin
      bwr(CFG_ADDR, e ? 8'h38 : 8'h28);
      bwr(TC_ADDR, 8'h00);
      repeat (10) @(posedge clk_in);
      src.hold_level(1'b1);
      repeat (12) @(posedge clk_in);
      rchk("rise_seen", TC_ADDR, e ? 8'h00 : 8'h01);
      src.hold_level(1'b0);
      repeat (12) @(posedge clk_in);
      rchk("fall_seen", TC_ADDR, 8'h01);
      k = 1 + ($random(seed) & 15);
      src.burst(k, 3 + ($random(seed) & 3), 3 + ($random(seed) & 3));
      repeat (12) @(posedge clk_in);
      rchk("pin_count", TC_ADDR, 8'(k + 1));
    end
    // Watchdog postscaler with prescaler cleared on watchdog clear
    for (int r = 0; r < 4; r++)
    begin
      bwr(CFG_ADDR, 8'(8'h28 | r));
      ticks(3, n);
      pulse_clr();
      ticks(2 << r, n);
      chk8("wdt_timeouts", 8'h02, 8'(n));
    end
    // Timer mode: unscaled, then every ratio
    for (int r = -1; r < 8; r++)
    begin
      // clear before handing prescaler to timer
      if (r == 0)
        pulse_clr();
      bwr(CFG_ADDR, (r < 0) ? 8'h08 : 8'(r));
      k = (r < 0) ? 4 : tmr_div(r);
      bwr(TC_ADDR, 8'h00);
      repeat (6 * k) @(posedge clk_in);
      brd(TC_ADDR, v);
      chk_rng("timer_steps", steps_lo(k), steps_hi(k), v);
    end
    // Scaled pin counting through the prescaler
    for (int r = 0; r < 2; r++)
    begin
      bwr(CFG_ADDR, 8'(8'h20 | r));
      bwr(TC_ADDR, 8'h00);
      // let the write hold-off run out before the first pulse
      repeat (10) @(posedge clk_in);
      k = 1 + ($random(seed) & 7);
      src.burst(k << (r + 1), 2, 2);
      repeat (12) @(posedge clk_in);
      rchk("scaled_pins", TC_ADDR, 8'(k));
    end
    ticks(5, n);
    chk8("wdt_unscaled", 8'h05, 8'(n));
    // move prescaler to watchdog with interim ratio
    pulse_clr();
    bwr(TC_ADDR, 8'h00);
    bwr(CFG_ADDR, 8'h2f);
    pulse_clr();
    bwr(CFG_ADDR, 8'h08);
    // Overflow flag and delayed interrupt
    bwr(IC_ADDR, 8'h20);
    bwr(TC_ADDR, 8'hfe);
    n = 0;
    while (irq !== 1'b1 && n < 60)
    begin
      @(posedge clk_in);
      #1 n++;
    end
    chk_rng("irq_delay", 24, 28, 8'(n));
    rchk("flag_set", IC_ADDR, 8'h24);
    bwr(IC_ADDR, 8'h20);
    repeat (2) @(posedge clk_in);
    #1 chk8("irq_clear", 8'h00, {7'h00, irq});
    bwr(IC_ADDR, 8'h00);
    bwr(TC_ADDR, 8'hff);
    repeat (40) @(posedge clk_in);
    #1 chk8("irq_masked", 8'h00, {7'h00, irq});
    rchk("flag_masked", IC_ADDR, 8'h04);
    results();
  end

  // Cuts a hang short
  initial
  begin
    #(CLK_NS * 40000);
    bad_count++;
    results();
  end
endmodule
